// ==== core/tmpal_bus_if.sv ====
// Two-wire bus and alert line joining the sensor end and the master end.
// Open-drain lines with pull-ups: a line is low when any enabled driver outputs low.
`timescale 1ns/1ps
interface tmpal_bus_if;
	logic mstSclOut;
	logic mstSclOe_n;
	logic mstSdaOut;
	logic mstSdaOe_n;
	logic devSdaOut;
	logic devSdaOe_n;
	logic alertPin;
	logic scl;
	logic sda;

	assign scl = mstSclOe_n | mstSclOut;
	assign sda = (mstSdaOe_n | mstSdaOut) & (devSdaOe_n | devSdaOut);

	modport device (
		input  scl,
		input  sda,
		output devSdaOut,
		output devSdaOe_n,
		output alertPin
	);

	modport host (
		input  scl,
		input  sda,
		input  alertPin,
		output mstSclOut,
		output mstSclOe_n,
		output mstSdaOut,
		output mstSdaOe_n
	);
endinterface

// ==== core/tmpal_device.sv ====
// Sensor end: two-wire slave, register file and over-temperature alert.
// Assumes conversion results arrive from logic on clk_sys with a one-cycle convDone.
`timescale 1ns/1ps
module tmpal_device #(
	parameter int TIMEOUT_CYCLES = tmpal_pkg::TIMEOUT_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	tmpal_bus_if.device      bus,
	input  wire logic        addrStrap2,
	input  wire logic        addrStrap1,
	input  wire logic        addrStrap0,
	input  wire logic        convDone,
	input  wire logic [11:0] convResult,
	output logic             shutdownMode,
	output logic             alertActive
);

	localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

	if (TIMEOUT_CYCLES < 16)
	begin : g_chk
		$error("TIMEOUT_CYCLES too small");
	end

	typedef struct packed {
		logic [2:0]        sclSync;
		logic [2:0]        sdaSync;
		logic [2:0]        strapMeta;
		logic [2:0]        strapSync;
		logic [2:0]        strap;
		tmpal_pkg::tmpal_slv_t st;
		logic [3:0]        bitCnt;
		logic [7:0]        shift;
		logic [1:0]        byteIdx;
		logic              rw;
		logic              gcall;
		logic              ara;
		logic              ack;
		logic [1:0]        ptr;
		logic [15:0]       temp;
		logic [15:0]       cfg;
		logic [15:0]       tlow;
		logic [15:0]       thigh;
		logic [2:0]        faultCnt;
		logic              alertOn;
		logic              armHigh;
		logic              alertHigh;
		logic              shutPrev;
		logic              sdaOe_n;
		logic              alertPin;
		logic [TW-1:0]     toCnt;
	} tmpal_dev_state_t;

	localparam tmpal_dev_state_t RST_STATE = '{
		sclSync:  3'h7,
		sdaSync:  3'h7,
		st:       tmpal_pkg::TMPAL_IDLE,
		temp:     tmpal_pkg::RST_TEMP,
		cfg:      tmpal_pkg::RST_CFG,
		tlow:     tmpal_pkg::RST_TLOW,
		thigh:    tmpal_pkg::RST_THIGH,
		armHigh:  1'b1,
		sdaOe_n:  1'b1,
		alertPin: 1'b1,
		default:  '0
	};

	tmpal_dev_state_t r;
	tmpal_dev_state_t n;

	logic        sclH;
	logic        sdaH;
	logic        sclRise;
	logic        sclFall;
	logic        start;
	logic        stop;
	logic [6:0]  selfAddr;
	logic [15:0] rdReg;
	logic [15:0] wrVal;
	logic [15:0] res16;
	logic        hot;
	logic        cold;
	logic        pending;
	logic        regRead;
	logic        araWin;
	logic        gcReset;
	logic        latching;
	logic [2:0]  cntInc;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		n = r;
		n.sclSync = {r.sclSync[1:0], bus.scl};
		n.sdaSync = {r.sdaSync[1:0], bus.sda};
		n.strapMeta = {addrStrap2, addrStrap1, addrStrap0};
		n.strapSync = r.strapMeta;
		sclH = r.sclSync[1];
		sdaH = r.sdaSync[1];
		sclRise = sclH & ~r.sclSync[2];
		sclFall = ~sclH & r.sclSync[2];
		start = sclH & r.sclSync[2] & r.sdaSync[2] & ~sdaH;
		stop = sclH & r.sclSync[2] & ~r.sdaSync[2] & sdaH;
		selfAddr = {tmpal_pkg::ADDR_FIXED, r.strap};
		regRead = 1'b0;
		araWin = 1'b0;
		gcReset = 1'b0;
		case (r.ptr)
			tmpal_pkg::PTR_TEMP: rdReg = r.temp;
			tmpal_pkg::PTR_CFG:  rdReg = r.cfg;
			tmpal_pkg::PTR_TLOW: rdReg = r.tlow;
			default:             rdReg = r.thigh;
		endcase
		wrVal = (r.byteIdx == 2'h1) ? {r.shift, rdReg[7:0]} : {rdReg[15:8], r.shift};

		// Slave protocol engine
		if (start)
		begin
			n.st = tmpal_pkg::TMPAL_ADDR;
			n.bitCnt = 4'h0;
			n.byteIdx = 2'h0;
			n.gcall = 1'b0;
			n.ara = 1'b0;
			n.sdaOe_n = 1'b1;
			n.strap = r.strapSync;
		end
		else if (stop)
		begin
			n.st = tmpal_pkg::TMPAL_IDLE;
			n.sdaOe_n = 1'b1;
		end
		else
		begin
			case (r.st)
				tmpal_pkg::TMPAL_IDLE:
				begin
					n.sdaOe_n = 1'b1;
				end
				tmpal_pkg::TMPAL_ADDR, tmpal_pkg::TMPAL_RX:
				begin
					if (sclRise)
					begin
						n.shift = {r.shift[6:0], sdaH};
						n.bitCnt = 4'(r.bitCnt + 4'h1);
					end
					else if (sclFall && r.bitCnt == tmpal_pkg::BITS_PER_BYTE)
					begin
						n.sdaOe_n = 1'b0;
						if (r.st == tmpal_pkg::TMPAL_RX)
						begin
							n.st = tmpal_pkg::TMPAL_RXACK;
							n.byteIdx = (r.byteIdx == 2'h3) ? 2'h3 : 2'(r.byteIdx + 2'h1);
							if (r.gcall)
							begin
								if (r.shift == tmpal_pkg::GC_RESET)
									gcReset = 1'b1;
								if (r.shift == tmpal_pkg::GC_RELATCH)
									n.strap = r.strapSync;
							end
							else if (r.byteIdx == 2'h0)
								n.ptr = r.shift[1:0];
							else if (r.byteIdx != 2'h3)
							begin
								case (r.ptr)
									tmpal_pkg::PTR_CFG:   n.cfg = wrVal;
									tmpal_pkg::PTR_TLOW:  n.tlow = wrVal;
									tmpal_pkg::PTR_THIGH: n.thigh = wrVal;
									default:              n.temp = r.temp;
								endcase
							end
						end
						else if (r.shift[7:1] == selfAddr)
						begin
							n.st = tmpal_pkg::TMPAL_ADDRACK;
							n.rw = r.shift[0];
							regRead = r.shift[0];
						end
						else if (r.shift == tmpal_pkg::GCALL_BYTE)
						begin
							n.st = tmpal_pkg::TMPAL_ADDRACK;
							n.rw = 1'b0;
							n.gcall = 1'b1;
						end
						else if (r.shift == tmpal_pkg::ARA_BYTE && r.alertOn)
						begin
							n.st = tmpal_pkg::TMPAL_ADDRACK;
							n.rw = 1'b1;
							n.ara = 1'b1;
						end
						else
						begin
							n.st = tmpal_pkg::TMPAL_IDLE;
							n.sdaOe_n = 1'b1;
						end
					end
				end
				tmpal_pkg::TMPAL_ADDRACK, tmpal_pkg::TMPAL_RXACK, tmpal_pkg::TMPAL_TXACK:
				begin
					if (sclRise)
						n.ack = ~sdaH;
					if (sclFall)
					begin
						n.bitCnt = 4'h0;
						n.sdaOe_n = 1'b1;
						if (r.st == tmpal_pkg::TMPAL_TXACK && !(r.ack && !r.ara))
							n.st = tmpal_pkg::TMPAL_IDLE;
						else if (r.rw)
						begin
							// Response byte or alternating MSB/LSB of the pointed register
							n.st = tmpal_pkg::TMPAL_TX;
							n.shift = r.ara ? {selfAddr, r.alertHigh} :
								((r.byteIdx[0]) ? rdReg[7:0] : rdReg[15:8]);
							n.sdaOe_n = r.ara ? selfAddr[6] :
								((r.byteIdx[0]) ? rdReg[7] : rdReg[15]);
						end
						else
							n.st = tmpal_pkg::TMPAL_RX;
					end
				end
				tmpal_pkg::TMPAL_TX:
				begin
					if (sclRise)
					begin
						n.bitCnt = 4'(r.bitCnt + 4'h1);
						// Released a one but the line is low: another responder won
						if (r.ara && r.shift[7] && !sdaH)
						begin
							n.st = tmpal_pkg::TMPAL_IDLE;
							n.sdaOe_n = 1'b1;
						end
					end
					else if (sclFall)
					begin
						if (r.bitCnt == tmpal_pkg::BITS_PER_BYTE)
						begin
							n.st = tmpal_pkg::TMPAL_TXACK;
							n.sdaOe_n = 1'b1;
							n.byteIdx = {1'b0, ~r.byteIdx[0]};
							araWin = r.ara;
						end
						else
						begin
							n.shift = {r.shift[6:0], 1'b0};
							n.sdaOe_n = r.shift[6];
						end
					end
				end
				default:
				begin
					n.st = tmpal_pkg::TMPAL_IDLE;
					n.sdaOe_n = 1'b1;
				end
			endcase
		end

		// Stuck bus watchdog; each SCL rise restarts it, so zero-bit runs never time out
		if (r.st != tmpal_pkg::TMPAL_IDLE && (!sclH || !sdaH) && !sclRise)
		begin
			n.toCnt = TW'(r.toCnt + 1'b1);
			if (r.toCnt == TW'(TIMEOUT_CYCLES - 1))
			begin
				n.st = tmpal_pkg::TMPAL_IDLE;
				n.sdaOe_n = 1'b1;
				n.toCnt = '0;
			end
		end
		else
			n.toCnt = '0;

		// Alert engine
		res16 = {convResult, 4'h0};
		hot = $signed(res16) >= $signed(r.thigh);
		cold = $signed(res16) < $signed(r.tlow);
		latching = r.cfg[tmpal_pkg::CFG_LATCH];
		pending = r.armHigh ? hot : cold;
		cntInc = 3'(r.faultCnt + 3'h1);
		n.shutPrev = r.cfg[tmpal_pkg::CFG_SHUTDOWN];
		if (convDone)
			n.temp = res16;
		if (latching && r.alertOn)
		begin
			// Firing is blocked while latched, so a clear never races a set
			if (regRead || araWin || (r.cfg[tmpal_pkg::CFG_SHUTDOWN] && !r.shutPrev))
			begin
				n.alertOn = 1'b0;
				n.armHigh = ~r.armHigh;
				n.faultCnt = 3'h0;
			end
		end
		else if (convDone)
		begin
			if (!pending)
				n.faultCnt = 3'h0;
			else if (cntInc >= tmpal_pkg::tmpal_qlen_count(r.cfg[tmpal_pkg::CFG_QLEN_LO +: 2]))
			begin
				n.faultCnt = 3'h0;
				if (latching)
				begin
					n.alertOn = 1'b1;
					n.alertHigh = r.armHigh;
				end
				else
				begin
					n.alertOn = r.armHigh;
					n.alertHigh = 1'b1;
					n.armHigh = ~r.armHigh;
				end
			end
			else
				n.faultCnt = cntInc;
		end

		if (gcReset)
		begin
			n.temp = tmpal_pkg::RST_TEMP;
			n.cfg = tmpal_pkg::RST_CFG;
			n.tlow = tmpal_pkg::RST_TLOW;
			n.thigh = tmpal_pkg::RST_THIGH;
			n.ptr = tmpal_pkg::PTR_TEMP;
			n.faultCnt = 3'h0;
			n.alertOn = 1'b0;
			n.armHigh = 1'b1;
			n.alertHigh = 1'b0;
		end
		n.alertPin = n.cfg[tmpal_pkg::CFG_SENSE] ? n.alertOn : ~n.alertOn;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			r <= RST_STATE;
		else
			r <= n;
	end

	assign bus.devSdaOut = 1'b0;
	assign bus.devSdaOe_n = r.sdaOe_n;
	assign bus.alertPin = r.alertPin;
	assign shutdownMode = r.cfg[tmpal_pkg::CFG_SHUTDOWN];
	assign alertActive = r.alertOn;

endmodule

// ==== core/tmpal_host.sv ====
// Master end: issues one start/address/data/stop transaction per command.
// Assumes the slave never stretches SCL; repeated start is done as two commands.
`timescale 1ns/1ps
module tmpal_host #(
	parameter int SCL_QUARTER = tmpal_pkg::SCL_QUARTER
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	tmpal_bus_if.host        bus,
	input  wire logic        cmdValid,
	output logic             cmdReady,
	input  wire logic [6:0]  cmdAddr,
	input  wire logic        cmdRead,
	input  wire logic [1:0]  cmdLen,
	input  wire logic [23:0] cmdData,
	output logic             done,
	output logic             nack,
	output logic [15:0]      rdData,
	output logic             alertSeen
);

	localparam int QW = $clog2(SCL_QUARTER + 1);

	if (SCL_QUARTER < 4)
	begin : g_chk
		$error("SCL_QUARTER too small for input synchroniser");
	end

	typedef struct packed {
		tmpal_pkg::tmpal_mst_t st;
		logic [QW-1:0] qCnt;
		logic [1:0]    phase;
		logic [3:0]    bitCnt;
		logic [1:0]    byteIdx;
		logic [1:0]    len;
		logic          rd;
		logic [7:0]    shift;
		logic [23:0]   data;
		logic [1:0]    sdaSync;
		logic [1:0]    alertSync;
		logic          sclOe_n;
		logic          sdaOe_n;
		logic          done;
		logic          nack;
		logic [15:0]   rdData;
	} tmpal_host_state_t;

	localparam tmpal_host_state_t RST_STATE = '{
		st:      tmpal_pkg::TMPAL_M_IDLE,
		sdaSync: 2'h3,
		alertSync: 2'h3,
		sclOe_n: 1'b1,
		sdaOe_n: 1'b1,
		default: '0
	};

	tmpal_host_state_t r;
	tmpal_host_state_t n;
	logic tick;
	logic rxByte;

	always_comb
	begin
		n = r;
		n.sdaSync = {r.sdaSync[0], bus.sda};
		n.alertSync = {r.alertSync[0], bus.alertPin};
		n.done = 1'b0;
		tick = (r.qCnt == QW'(SCL_QUARTER - 1));
		rxByte = r.rd && (r.byteIdx != 2'h0);
		n.qCnt = tick ? '0 : QW'(r.qCnt + 1'b1);
		if (tick)
			n.phase = 2'(r.phase + 2'h1);
		case (r.st)
			tmpal_pkg::TMPAL_M_IDLE:
			begin
				n.qCnt = '0;
				n.phase = 2'h0;
				if (cmdValid)
				begin
					n.st = tmpal_pkg::TMPAL_M_START;
					n.shift = {cmdAddr, cmdRead};
					n.data = cmdData;
					n.len = cmdLen;
					n.rd = cmdRead;
					n.byteIdx = 2'h0;
					n.bitCnt = 4'h0;
					n.nack = 1'b0;
				end
			end
			tmpal_pkg::TMPAL_M_START:
			begin
				if (tick && r.phase == 2'h0)
					n.sdaOe_n = 1'b0;
				if (tick && r.phase == 2'h3)
				begin
					n.sclOe_n = 1'b0;
					n.st = tmpal_pkg::TMPAL_M_BIT;
				end
			end
			tmpal_pkg::TMPAL_M_BIT:
			begin
				if (tick && r.phase == 2'h0)
				begin
					// Data changes only while SCL is low
					if (r.bitCnt == tmpal_pkg::BITS_PER_BYTE)
						n.sdaOe_n = !(rxByte && r.byteIdx != r.len);
					else
						n.sdaOe_n = rxByte | r.shift[7];
				end
				if (tick && r.phase == 2'h1)
					n.sclOe_n = 1'b1;
				if (tick && r.phase == 2'h3)
				begin
					n.sclOe_n = 1'b0;
					n.bitCnt = 4'(r.bitCnt + 4'h1);
					if (r.bitCnt != tmpal_pkg::BITS_PER_BYTE)
						n.shift = {r.shift[6:0], rxByte ? r.sdaSync[1] : 1'b0};
					else
					begin
						n.bitCnt = 4'h0;
						if (rxByte)
							n.rdData = {r.rdData[7:0], r.shift};
						if (!rxByte && r.sdaSync[1])
						begin
							n.nack = 1'b1;
							n.st = tmpal_pkg::TMPAL_M_STOP;
						end
						else if (r.byteIdx == r.len)
							n.st = tmpal_pkg::TMPAL_M_STOP;
						else
						begin
							n.byteIdx = 2'(r.byteIdx + 2'h1);
							n.shift = r.rd ? 8'h00 : r.data[23:16];
							n.data = {r.data[15:0], 8'h00};
						end
					end
				end
			end
			tmpal_pkg::TMPAL_M_STOP:
			begin
				if (tick && r.phase == 2'h0)
					n.sdaOe_n = 1'b0;
				if (tick && r.phase == 2'h1)
					n.sclOe_n = 1'b1;
				if (tick && r.phase == 2'h2)
					n.sdaOe_n = 1'b1;
				if (tick && r.phase == 2'h3)
				begin
					n.st = tmpal_pkg::TMPAL_M_IDLE;
					n.done = 1'b1;
				end
			end
			default:
			begin
				n.st = tmpal_pkg::TMPAL_M_IDLE;
				n.sclOe_n = 1'b1;
				n.sdaOe_n = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			r <= RST_STATE;
		else
			r <= n;
	end

	assign cmdReady = (r.st == tmpal_pkg::TMPAL_M_IDLE);
	assign bus.mstSclOut = 1'b0;
	assign bus.mstSdaOut = 1'b0;
	assign bus.mstSclOe_n = r.sclOe_n;
	assign bus.mstSdaOe_n = r.sdaOe_n;
	assign done = r.done;
	assign nack = r.nack;
	assign rdData = r.rdData;
	assign alertSeen = r.alertSync[1];

endmodule

// ==== core/tmpal_pkg.sv ====
// Shared constants and types for the temperature alert two-wire slave and its master.
// Assumes one system clock of CLK_KHZ on both ends.
package tmpal_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int CLK_KHZ        = 50000;
	localparam int TIMEOUT_MS     = 54;
	localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLK_KHZ;
	localparam int SCL_KHZ        = 400;
	// Quarter of an SCL period, rounded up so SCL never runs too fast
	localparam int SCL_QUARTER    = (CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);

	// ************************************************************
	// Bus addresses and commands
	// ************************************************************
	localparam logic [3:0] ADDR_FIXED    = 4'h9;
	localparam logic [7:0] GCALL_BYTE    = 8'h00;
	localparam logic [7:0] ARA_BYTE      = 8'h19;
	localparam logic [7:0] GC_RESET      = 8'h06;
	localparam logic [7:0] GC_RELATCH    = 8'h04;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ************************************************************
	// Register pointers, fields and reset values
	// ************************************************************
	localparam logic [1:0] PTR_TEMP  = 2'h0;
	localparam logic [1:0] PTR_CFG   = 2'h1;
	localparam logic [1:0] PTR_TLOW  = 2'h2;
	localparam logic [1:0] PTR_THIGH = 2'h3;
	localparam int CFG_SHUTDOWN = 8;
	localparam int CFG_LATCH    = 9;
	localparam int CFG_SENSE    = 10;
	localparam int CFG_QLEN_LO  = 11;
	localparam logic [15:0] RST_TEMP  = 16'h0000;
	localparam logic [15:0] RST_CFG   = 16'h0000;
	localparam logic [15:0] RST_TLOW  = 16'h4b00;
	localparam logic [15:0] RST_THIGH = 16'h5000;

	// ************************************************************
	// State encodings
	// ************************************************************
	typedef enum logic [2:0] {
		TMPAL_IDLE    = 3'h0,
		TMPAL_ADDR    = 3'h1,
		TMPAL_ADDRACK = 3'h3,
		TMPAL_RX      = 3'h2,
		TMPAL_RXACK   = 3'h6,
		TMPAL_TX      = 3'h7,
		TMPAL_TXACK   = 3'h5
	} tmpal_slv_t;

	typedef enum logic [1:0] {
		TMPAL_M_IDLE  = 2'h0,
		TMPAL_M_START = 2'h1,
		TMPAL_M_BIT   = 2'h3,
		TMPAL_M_STOP  = 2'h2
	} tmpal_mst_t;

	// Fault queue setting to consecutive conversion count
	function automatic logic [2:0] tmpal_qlen_count(input logic [1:0] qlen);
		case (qlen)
			2'h0:    return 3'h1;
			2'h1:    return 3'h2;
			2'h2:    return 3'h4;
			default: return 3'h6;
		endcase
	endfunction

endpackage

// ==== tb/temp_alert_twowire_slave_tb_top.sv ====
// Bench driving the master end's commands and the sensor end's conversions.
// Assumes package, bus interface and both ends are compiled before it.
`timescale 1ns/1ps
module temp_alert_twowire_slave_tb_top;
	// 2.5 MHz SCL, inside the high-speed limit
	localparam int QUARTER = 5;
	localparam int TIMEOUT = 2000;
	localparam logic [11:0] HOT  = 12'h510;
	localparam logic [11:0] MID  = 12'h4c8;
	localparam logic [11:0] COLD = 12'h400;
	localparam logic [6:0]  ARA  = 7'h0c;
	logic        clk_sys;
	logic        rst_n;
	logic [2:0]  strap;
	logic        convDone;
	logic [11:0] convResult;
	logic        shutdownMode;
	logic        alertActive;
	logic        cmdValid;
	logic        cmdReady;
	logic [6:0]  cmdAddr;
	logic        cmdRead;
	logic [1:0]  cmdLen;
	logic [23:0] cmdData;
	logic        done;
	logic        nack;
	logic [15:0] rdData;
	logic        alertSeen;
	logic [6:0]  devAddr;
	int          bad_count;
	int          comparisons;

	// ************************************************************
	// Both ends on one bus
	// ************************************************************
	assign devAddr = {tmpal_pkg::ADDR_FIXED, strap};
	tmpal_bus_if i_tmpal_bus_if ();
	tmpal_device #(.TIMEOUT_CYCLES(TIMEOUT)) i_tmpal_device (.clk_sys(clk_sys), .rst_n(rst_n),
		.bus(i_tmpal_bus_if), .addrStrap2(strap[2]), .addrStrap1(strap[1]),
		.addrStrap0(strap[0]), .convDone(convDone), .convResult(convResult),
		.shutdownMode(shutdownMode), .alertActive(alertActive));
	tmpal_host #(.SCL_QUARTER(QUARTER)) i_tmpal_host (.clk_sys(clk_sys), .rst_n(rst_n),
		.bus(i_tmpal_bus_if), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdAddr(cmdAddr),
		.cmdRead(cmdRead), .cmdLen(cmdLen), .cmdData(cmdData), .done(done), .nack(nack),
		.rdData(rdData), .alertSeen(alertSeen));
	tmpal_bus_sva #(.SCL_QUARTER(QUARTER)) i_tmpal_bus_sva (.clk_sys(clk_sys), .rst_n(rst_n),
		.scl(i_tmpal_bus_if.scl), .sda(i_tmpal_bus_if.sda),
		.mstSclOut(i_tmpal_bus_if.mstSclOut), .mstSclOe_n(i_tmpal_bus_if.mstSclOe_n),
		.mstSdaOut(i_tmpal_bus_if.mstSdaOut), .mstSdaOe_n(i_tmpal_bus_if.mstSdaOe_n),
		.devSdaOut(i_tmpal_bus_if.devSdaOut), .devSdaOe_n(i_tmpal_bus_if.devSdaOe_n),
		.alertPin(i_tmpal_bus_if.alertPin));

	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// ************************************************************
	// Drivers and compares
	// ************************************************************
	task automatic test_done();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		check(what, {15'h0000, exp}, {15'h0000, got});
	endtask
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask
	// One whole transaction; ready is high again from the done cycle on
	task automatic xfer(input logic [6:0] a, input logic rd, input logic [1:0] len,
		input logic [23:0] d);
		int n;
		cmdAddr  = a;
		cmdRead  = rd;
		cmdLen   = len;
		cmdData  = d;
		cmdValid = 1'b1;
		tick();
		cmdValid = 1'b0;
		chk_bit("cmdReady busy", 1'b0, cmdReady);
		n = 0;
		while (done !== 1'b1 && n < TIMEOUT)
		begin
			tick();
			n++;
		end
		if (done !== 1'b1)
		begin
			bad_count++;
			$display("BAD done expected 1 seen 0");
			test_done();
		end
		else
			chk_bit("cmdReady done", 1'b1, cmdReady);
	endtask
	task automatic wreg(input logic [1:0] ptr, input logic [15:0] val);
		xfer(devAddr, 1'b0, 2'h3, {6'h00, ptr, val});
	endtask
	task automatic rreg(input logic [1:0] ptr, input string what, input logic [15:0] exp);
		xfer(devAddr, 1'b0, 2'h1, {6'h00, ptr, 16'h0000});
		xfer(devAddr, 1'b1, 2'h2, 24'h000000);
		check(what, exp, rdData);
	endtask
	task automatic conv(input logic [11:0] val, input logic exp);
		convResult = val;
		convDone   = 1'b1;
		tick();
		convDone = 1'b0;
		tick();
		chk_bit("alertActive", exp, alertActive);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_registers();
		rreg(tmpal_pkg::PTR_THIGH, "thigh", tmpal_pkg::RST_THIGH);
		chk_bit("nack", 1'b0, nack);
		wreg(tmpal_pkg::PTR_TLOW, 16'h4c30);
		rreg(tmpal_pkg::PTR_TLOW, "tlow", 16'h4c30);
		xfer(devAddr, 1'b1, 2'h2, 24'h000000);
		check("reread", 16'h4c30, rdData);
		wreg(tmpal_pkg::PTR_TEMP, 16'h1230);
		rreg(tmpal_pkg::PTR_TEMP, "temp", tmpal_pkg::RST_TEMP);
		xfer(7'h2a, 1'b1, 2'h2, 24'h000000);
		chk_bit("nack", 1'b1, nack);
		$display("t_registers finished");
	endtask
	task automatic t_comparator();
		conv(HOT, 1'b1);
		chk_bit("alertPin", 1'b0, i_tmpal_bus_if.alertPin);
		conv(MID, 1'b1);
		conv(COLD, 1'b0);
		conv(12'h500, 1'b1);
		conv(COLD, 1'b0);
		rreg(tmpal_pkg::PTR_TEMP, "temp", {COLD, 4'h0});
		chk_bit("alertSeen", 1'b1, alertSeen);
		wreg(tmpal_pkg::PTR_CFG, 16'h0800);
		conv(HOT, 1'b0);
		conv(COLD, 1'b0);
		conv(HOT, 1'b0);
		conv(HOT, 1'b1);
		conv(COLD, 1'b1);
		conv(COLD, 1'b0);
		wreg(tmpal_pkg::PTR_CFG, 16'h1800);
		repeat (5) conv(HOT, 1'b0);
		conv(HOT, 1'b1);
		repeat (5) conv(COLD, 1'b1);
		conv(COLD, 1'b0);
		$display("t_comparator finished");
	endtask
	task automatic t_interrupt();
		wreg(tmpal_pkg::PTR_CFG, 16'h0200);
		conv(HOT, 1'b1);
		conv(COLD, 1'b1);
		rreg(tmpal_pkg::PTR_CFG, "cfg", 16'h0200);
		chk_bit("alertActive", 1'b0, alertActive);
		conv(HOT, 1'b0);
		conv(COLD, 1'b1);
		xfer(ARA, 1'b1, 2'h1, 24'h000000);
		check("ara", {8'h00, devAddr, 1'b0}, {8'h00, rdData[7:0]});
		chk_bit("alertActive", 1'b0, alertActive);
		xfer(ARA, 1'b1, 2'h1, 24'h000000);
		chk_bit("nack", 1'b1, nack);
		conv(HOT, 1'b1);
		xfer(ARA, 1'b1, 2'h1, 24'h000000);
		check("ara", {8'h00, devAddr, 1'b1}, {8'h00, rdData[7:0]});
		conv(COLD, 1'b1);
		wreg(tmpal_pkg::PTR_CFG, 16'h0300);
		chk_bit("alertActive", 1'b0, alertActive);
		chk_bit("shutdownMode", 1'b1, shutdownMode);
		$display("t_interrupt finished");
	endtask
	task automatic t_sense_gcall();
		wreg(tmpal_pkg::PTR_CFG, 16'h0400);
		chk_bit("alertPin", 1'b0, i_tmpal_bus_if.alertPin);
		conv(HOT, 1'b1);
		chk_bit("alertPin", 1'b1, i_tmpal_bus_if.alertPin);
		wreg(tmpal_pkg::PTR_CFG, 16'h0600);
		xfer(7'h00, 1'b0, 2'h1, {tmpal_pkg::GC_RESET, 16'h0000});
		chk_bit("alertActive", 1'b0, alertActive);
		chk_bit("alertPin", 1'b1, i_tmpal_bus_if.alertPin);
		rreg(tmpal_pkg::PTR_CFG, "cfg", tmpal_pkg::RST_CFG);
		rreg(tmpal_pkg::PTR_TLOW, "tlow", tmpal_pkg::RST_TLOW);
		conv(HOT, 1'b1);
		conv(COLD, 1'b0);
		strap = 3'h5;
		xfer(7'h00, 1'b0, 2'h1, {tmpal_pkg::GC_RELATCH, 16'h0000});
		rreg(tmpal_pkg::PTR_THIGH, "thigh", tmpal_pkg::RST_THIGH);
		chk_bit("nack", 1'b0, nack);
		$display("t_sense_gcall finished");
	endtask

	initial
	begin
		rst_n       = 1'b0;
		strap       = 3'h3;
		convDone    = 1'b0;
		convResult  = 12'h000;
		cmdValid    = 1'b0;
		cmdAddr     = 7'h00;
		cmdRead     = 1'b0;
		cmdLen      = 2'h0;
		cmdData     = 24'h000000;
		bad_count   = 0;
		comparisons = 0;
		repeat (10) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		repeat (4) tick();
		t_registers();
		t_comparator();
		t_interrupt();
		t_sense_gcall();
		test_done();
	end
endmodule

// ==== tb/tmpal_bus_sva.sv ====
// Checker for the two-wire lines and alert pin between the two ends.
// Assumes the lines of one bus interface, sampled on clk_sys.
`timescale 1ns/1ps
module tmpal_bus_sva #(
	parameter int SCL_QUARTER = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic mstSclOut,
	input wire logic mstSclOe_n,
	input wire logic mstSdaOut,
	input wire logic mstSdaOe_n,
	input wire logic devSdaOut,
	input wire logic devSdaOe_n,
	input wire logic alertPin
);
	// Ack plus eight zero bits is the longest legal pull, plus sync slack
	localparam int DRV_MAX = 36 * SCL_QUARTER + 8;
	localparam int LOW_MIN = 2 * SCL_QUARTER - 1;
	localparam int LOW_MAX = 2 * SCL_QUARTER + 1;
	logic       sclD;
	logic       sdaD;
	logic       inFrame;
	logic [3:0] bitCnt;
	logic [7:0] addrByte;
	logic [7:0] lowCnt;
	logic       ownAddr;
	logic       foreign;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// ************************************************************
	// Frame tracking
	// ************************************************************
	assign ownAddr = addrByte[7:4] == tmpal_pkg::ADDR_FIXED;
	assign foreign = !ownAddr && addrByte != tmpal_pkg::GCALL_BYTE
		&& addrByte != tmpal_pkg::ARA_BYTE;

	always_ff @(posedge clk_sys)
	begin
		sclD   <= scl;
		sdaD   <= sda;
		lowCnt <= scl ? 8'h00 : lowCnt + {7'h00, lowCnt != 8'hff};
		if (!rst_n)
			inFrame <= 1'b0;
		else if (scl && sclD && sdaD && !sda)
			inFrame <= 1'b1;
		else if (scl && sclD && !sdaD && sda)
			inFrame <= 1'b0;
		if (scl && sclD && sdaD && !sda)
			bitCnt <= 4'h0;
		else if (scl && !sclD && bitCnt != 4'hf)
			bitCnt <= bitCnt + 4'h1;
		if (scl && !sclD && bitCnt < 4'h8)
			addrByte <= {addrByte[6:0], sda};
	end

	// ************************************************************
	// Properties
	// ************************************************************
	sequence startSeq;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence addrDoneSeq;
		inFrame && scl && !sclD && bitCnt == 4'h8;
	endsequence

	odrain_low_a: assert property (!devSdaOut && !mstSdaOut && !mstSclOut)
		else $error("Open-drain output value not low");
	dev_edge_a: assert property ($changed(devSdaOe_n) |-> !scl)
		else $error("Sensor end moved SDA while SCL high");
	addr_ack_a: assert property (addrDoneSeq ##0 ownAddr |-> !devSdaOe_n)
		else $error("Own address not acknowledged");
	addr_refuse_a: assert property (addrDoneSeq ##0 foreign |-> devSdaOe_n)
		else $error("Foreign address acknowledged");
	idle_free_a: assert property (!inFrame |-> devSdaOe_n)
		else $error("Sensor end pulls SDA outside a frame");
	pull_bound_a: assert property ($fell(devSdaOe_n) |-> ##[1:DRV_MAX] devSdaOe_n)
		else $error("Sensor end holds SDA too long");
	scl_low_a: assert property ($rose(scl) |-> lowCnt inside {[LOW_MIN:LOW_MAX]})
		else $error("SCL low time off");
	start_hold_a: assert property (startSeq |-> scl [*4])
		else $error("SCL fell too soon after start");
	reset_idle_a: assert property ($rose(rst_n) |->
		devSdaOe_n && mstSdaOe_n && mstSclOe_n && alertPin)
		else $error("Lines not released after reset");
endmodule
